// [verilog/piopb_pkg.sv]
// Purpose: Constants and state types for the programmable port bank
// Assumes: 11 ports of 8 bits, one pin of them input only
// Notes on behaviour
// R1 - 87 port pins, each set to input or output by its own direction bit.
// R2 - The input-only pin has no direction bit, no pull-up, always input.
// R3 - One direction bit per pin; 1 drives the pin, 0 makes it an input.
// R4 - Data write loads the output latch; data read returns sampled pin level.
// R5 - One pull-up bit per four pins, applied only while the pin is input.
// R6 - A peripheral output drives the pin whatever its direction bit says.
// R7 - Software sets a pin to input before a peripheral uses it as input.
// R8 - Software never sets an analog output pin to output mode.
// R9 - An enabled analog output channel switches off its pin's pull-up.
// R10 - In expansion modes, direction bits of bus pins ignore writes.
// R11 - In expansion modes, latch bits of bus pins ignore writes.
// R12 - In expansion modes, pull-ups of ports 0-3, port 4 low, port 5 stay off.
// R13 - Readback bit 0 returns pin or latch per direction; 1 returns latch.
// R14 - Readback bit acts only with 8-bit external bus or multiplexed port use.
// R15 - After reset every pin is input with no pull-up.
package piopb_pkg;
  localparam int NPORT = 11;
  localparam int NPIN = 88;
  localparam int NGRP = 22;
  localparam int INONLY_IDX = 69;
  localparam int BUS_DATA_HIGH_PORT = 1;
  // Analog output pin positions: plain defaults
  localparam int DA0_IDX = 75;
  localparam int DA1_IDX = 76;
  // Pull-up groups switched off in expansion modes
  localparam logic [21:0] EXP_NOPU_GRP = 22'h000dff;
  // Register byte offsets
  localparam logic [11:0] OFS_DATA_BASE = 12'h000;
  localparam logic [11:0] OFS_DIR_BASE = 12'h040;
  localparam logic [11:0] OFS_PULL = 12'h080;
  localparam logic [11:0] OFS_PCTL = 12'h084;
  localparam logic [11:0] OFS_STAT = 12'h088;
  // Reset values
  localparam logic [87:0] DIR_RST = 88'h0;
  localparam logic [87:0] LAT_RST = 88'h0;
  localparam logic [21:0] PULL_RST = 22'h0;
  localparam logic PCTL_RST = 1'b0;

  typedef struct packed {
    logic [87:0] dir;
    logic [87:0] lat;
    logic [21:0] pull;
    logic rbsel;
    logic [31:0] rdata;
    logic [87:0] drv;
    logic [87:0] oe;
    logic [87:0] pu;
  } piopb_state_s;

  typedef struct packed {
    logic [87:0] s1;
    logic [87:0] s2;
    logic [87:0] s3;
    logic [87:0] lvl;
  } piopb_sync_s;
endpackage

// [verilog/piopb_sync_if.sv]
// Purpose: Carries raw pin levels to the filter and clean levels back
// Assumes: One clock domain on the user side
// Notes: Raw side is asynchronous to pclk
`timescale 1ns/10ps
interface piopb_sync_if;
  logic [87:0] raw;
  logic [87:0] level;
  modport user (output raw, input level);
  modport sync (input raw, output level);
endinterface

// [verilog/piopb_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins change asynchronously to pclk
// Notes: A level is taken only when stages two and three agree
`timescale 1ns/10ps
module piopb_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin levels
  piopb_sync_if.sync sif
);
  piopb_pkg::piopb_sync_s s_r;
  piopb_pkg::piopb_sync_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = sif.raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // Glitch shorter than a cycle never reaches the level
    s_nxt.lvl = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.lvl & (s_r.s2 ^ s_r.s3));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sif.level = s_r.lvl;
endmodule

// [verilog/piopb_top.sv]
// Purpose: Port bank with direction, latch, pull-up and readback control over APB
// Assumes: Bus-pin mask and mode levels come from the bus controller on pclk
// Notes: Pad outputs are registered, so they follow settings one cycle later
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module piopb_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating mode
  input wire logic exp_mode,
  input wire logic bus_8bit,
  input wire logic mux_port_mode,
  input wire logic [87:0] bus_pin_mask,
  // Peripherals
  input wire logic [87:0] periph_oe,
  input wire logic [87:0] periph_out,
  input wire logic [1:0] da_enable,
  // Pads
  input wire logic [87:0] pin_in,
  output logic [87:0] pin_out,
  output logic [87:0] pin_oe,
  output logic [87:0] pin_pullup
);
  piopb_pkg::piopb_state_s s_r;
  piopb_pkg::piopb_state_s s_nxt;
  piopb_sync_if sif();
  logic [3:0] widx;
  logic in_data;
  logic in_dir;
  logic hit;
  logic setup;
  logic access;
  logic rb_valid;
  logic [87:0] eff_oe;
  logic [87:0] level;

  function automatic logic [7:0] byte_of(input logic [87:0] v, input logic [3:0] i);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < piopb_pkg::NPORT; k++)
      if (i == 4'(k))
        r = v[8*k +: 8];
    return r;
  endfunction

  function automatic logic [87:0] put_byte(input logic [87:0] v, input logic [3:0] i,
                                           input logic [7:0] b, input logic [7:0] keep);
    logic [87:0] r;
    r = v;
    for (int k = 0; k < piopb_pkg::NPORT; k++)
      if (i == 4'(k))
        r[8*k +: 8] = (b & ~keep) | (v[8*k +: 8] & keep);
    return r;
  endfunction

  piopb_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  assign sif.raw = pin_in;
  assign level = sif.level;
  assign widx = paddr[5:2];
  assign in_data = (paddr[11:6] == piopb_pkg::OFS_DATA_BASE[11:6]) && (widx < 4'hb)
                   && (paddr[1:0] == 2'h0);
  assign in_dir = (paddr[11:6] == piopb_pkg::OFS_DIR_BASE[11:6]) && (widx < 4'hb)
                  && (paddr[1:0] == 2'h0);
  assign hit = in_data || in_dir || (paddr == piopb_pkg::OFS_PULL)
               || (paddr == piopb_pkg::OFS_PCTL) || (paddr == piopb_pkg::OFS_STAT);
  assign setup = psel && !penable;
  assign access = psel && penable;
  // Read data is registered in setup, so every access ends at once
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = s_r.rdata;
  assign rb_valid = (exp_mode && bus_8bit) || mux_port_mode; // R14
  assign eff_oe = s_r.dir | periph_oe; // R6

  always_comb
  begin
    logic [7:0] lock;
    logic [7:0] rv;
    logic [23:0] pm;
    logic grp_off;
    s_nxt = s_r;
    lock = exp_mode ? byte_of(bus_pin_mask, widx) : 8'h00; // R10 R11
    rv = 8'h00;
    pm = {2'h0, s_r.pull};
    grp_off = 1'b0;
    // Register writes take effect at the access edge
    if (access && pwrite && hit)
    begin
      if (in_data && pstrb[0])
        s_nxt.lat = put_byte(s_r.lat, widx, pwdata[7:0], lock); // R4 R11
      if (in_dir && pstrb[0])
        s_nxt.dir = put_byte(s_r.dir, widx, pwdata[7:0], lock); // R1 R3 R10
      if (paddr == piopb_pkg::OFS_PULL)
      begin
        for (int b = 0; b < 3; b++)
          if (pstrb[b])
            pm[8*b +: 8] = pwdata[8*b +: 8];
        s_nxt.pull = pm[21:0]; // R5 R12
      end
      if ((paddr == piopb_pkg::OFS_PCTL) && pstrb[0])
        s_nxt.rbsel = pwdata[0];
    end
    s_nxt.dir[piopb_pkg::INONLY_IDX] = 1'b0; // R2
    // Read data captured in the setup cycle
    if (setup)
    begin
      if (in_data)
      begin
        rv = byte_of(level, widx); // R4
        if ((widx == 4'(piopb_pkg::BUS_DATA_HIGH_PORT)) && rb_valid)
        begin
          if (s_r.rbsel)
            rv = byte_of(s_r.lat, widx); // R13
          else
            rv = (byte_of(s_r.dir, widx) & byte_of(s_r.lat, widx))
                 | (~byte_of(s_r.dir, widx) & byte_of(level, widx)); // R13
        end
        s_nxt.rdata = {24'h0, rv};
      end
      else if (in_dir)
        s_nxt.rdata = {24'h0, byte_of(s_r.dir, widx)};
      else if (paddr == piopb_pkg::OFS_PULL)
        s_nxt.rdata = {10'h0, s_r.pull};
      else if (paddr == piopb_pkg::OFS_PCTL)
        s_nxt.rdata = {31'h0, s_r.rbsel};
      else if (paddr == piopb_pkg::OFS_STAT)
        s_nxt.rdata = {27'h0, da_enable, mux_port_mode, bus_8bit, exp_mode};
      else
        s_nxt.rdata = 32'h0;
    end
    // Pad drive
    s_nxt.oe = eff_oe; // R3 R6
    s_nxt.oe[piopb_pkg::INONLY_IDX] = 1'b0; // R2
    s_nxt.drv = (periph_oe & periph_out) | (~periph_oe & s_r.lat); // R6
    for (int p = 0; p < piopb_pkg::NPIN; p++)
    begin
      grp_off = exp_mode && piopb_pkg::EXP_NOPU_GRP[p/4]; // R12
      s_nxt.pu[p] = s_r.pull[p/4] && !eff_oe[p] && !grp_off; // R5
      if ((p == piopb_pkg::DA0_IDX && da_enable[0]) || (p == piopb_pkg::DA1_IDX && da_enable[1]))
        s_nxt.pu[p] = 1'b0; // R9
      if (p == piopb_pkg::INONLY_IDX)
        s_nxt.pu[p] = 1'b0; // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0; // R15
      s_r.dir <= piopb_pkg::DIR_RST;
      s_r.lat <= piopb_pkg::LAT_RST;
      s_r.pull <= piopb_pkg::PULL_RST;
      s_r.rbsel <= piopb_pkg::PCTL_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign pin_out = s_r.drv;
  assign pin_oe = s_r.oe;
  assign pin_pullup = s_r.pu;

  // Checks
  a_inonly_never_driven: assert property (@(posedge pclk) disable iff (!presetn) // R2
    !pin_oe[piopb_pkg::INONLY_IDX] && !pin_pullup[piopb_pkg::INONLY_IDX])
    else $error("input-only pin driven or pulled up");

  a_oe_follows_dir: assert property (@(posedge pclk) disable iff (!presetn) // R3
    1'b1 |=> (pin_oe[7:0] == $past(s_r.dir[7:0] | periph_oe[7:0])))
    else $error("pad enable does not follow direction");

  a_dir_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // R1
    access && pwrite && in_dir && pstrb[0] && !exp_mode && (widx == 4'h2)
    |=> (s_r.dir[23:16] == $past(pwdata[7:0])) ##1 (pin_oe[23:16] == $past(s_r.dir[23:16]
    | periph_oe[23:16])))
    else $error("direction write lost");

  a_periph_override: assert property (@(posedge pclk) disable iff (!presetn) // R6
    periph_oe[10] |=> pin_oe[10] && (pin_out[10] == $past(periph_out[10])))
    else $error("peripheral output not driven");

  a_pullup_input_only: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (pin_pullup & pin_oe) == 88'h0)
    else $error("pull-up on driven pin");

  a_pullup_group_on: assert property (@(posedge pclk) disable iff (!presetn) // R5
    s_r.pull[12] && !eff_oe[49] |=> pin_pullup[49])
    else $error("group pull-up missing");

  a_pullup_da_off: assert property (@(posedge pclk) disable iff (!presetn) // R9
    da_enable[1] |=> !pin_pullup[piopb_pkg::DA1_IDX])
    else $error("pull-up on analog output");

  a_pullup_exp_off: assert property (@(posedge pclk) disable iff (!presetn) // R12
    exp_mode |=> (pin_pullup[35:0] == 36'h0) && (pin_pullup[47:40] == 8'h0))
    else $error("pull-up on bus pin in expansion");

  a_lock_dir_bits: assert property (@(posedge pclk) disable iff (!presetn) // R10
    access && pwrite && in_dir && exp_mode
    |=> ((byte_of(s_r.dir, $past(widx)) ^ $past(byte_of(s_r.dir, widx)))
    & $past(byte_of(bus_pin_mask, widx))) == 8'h0)
    else $error("locked direction bit changed");

  a_lock_lat_bits: assert property (@(posedge pclk) disable iff (!presetn) // R11
    access && pwrite && in_data && exp_mode
    |=> ((byte_of(s_r.lat, $past(widx)) ^ $past(byte_of(s_r.lat, widx)))
    & $past(byte_of(bus_pin_mask, widx))) == 8'h0)
    else $error("locked latch bit changed");

  a_read_pin_level: assert property (@(posedge pclk) disable iff (!presetn) // R4
    setup && in_data && (widx == 4'h0) |=> prdata == {24'h0, $past(level[7:0])})
    else $error("port read not pin level");

  a_read_latch_sel: assert property (@(posedge pclk) disable iff (!presetn) // R13
    setup && in_data && (widx == 4'h1) && rb_valid && s_r.rbsel
    |=> prdata[7:0] == $past(s_r.lat[15:8]))
    else $error("readback latch not returned");

  a_read_no_sel: assert property (@(posedge pclk) disable iff (!presetn) // R14
    setup && in_data && (widx == 4'h1) && !rb_valid
    |=> prdata[7:0] == $past(level[15:8]))
    else $error("readback select acted while invalid");

  a_reset_inputs: assert property (@(posedge pclk) // R15
    !presetn |-> (pin_oe == 88'h0) && (pin_pullup == 88'h0))
    else $error("pin not input during reset");

  a_lat_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // R4
    access && pwrite && in_data && pstrb[0] && !exp_mode && (widx == 4'h0)
    |=> s_r.lat[7:0] == $past(pwdata[7:0]))
    else $error("latch write lost");

  a_drv_follows_lat: assert property (@(posedge pclk) disable iff (!presetn) // R4
    !periph_oe[0] |=> pin_out[0] == $past(s_r.lat[0]))
    else $error("pad value does not follow latch");

  a_read_dir_back: assert property (@(posedge pclk) disable iff (!presetn) // R3
    setup && in_dir && (widx == 4'h3) |=> prdata == {24'h0, $past(s_r.dir[31:24])})
    else $error("direction readback wrong");

  a_read_mixed_sel: assert property (@(posedge pclk) disable iff (!presetn) // R13
    setup && in_data && (widx == 4'h1) && rb_valid && !s_r.rbsel
    |=> prdata[7:0] == $past((s_r.dir[15:8] & s_r.lat[15:8])
    | (~s_r.dir[15:8] & level[15:8])))
    else $error("mixed readback wrong");

  a_inonly_dir_zero: assert property (@(posedge pclk) disable iff (!presetn) // R2
    s_r.dir[piopb_pkg::INONLY_IDX] == 1'b0)
    else $error("input-only pin has a direction bit");

  a_pull_writable_exp: assert property (@(posedge pclk) disable iff (!presetn) // R12
    access && pwrite && (paddr == piopb_pkg::OFS_PULL) && exp_mode && (pstrb[2:0] == 3'h7)
    |=> s_r.pull == $past(pwdata[21:0]))
    else $error("pull-up bits not writable in expansion");

  a_pullup_da0_off: assert property (@(posedge pclk) disable iff (!presetn) // R9
    da_enable[0] |=> !pin_pullup[piopb_pkg::DA0_IDX])
    else $error("pull-up on analog output zero");

  a_pullup_exp_keeps: assert property (@(posedge pclk) disable iff (!presetn) // R12
    exp_mode && s_r.pull[12] && !eff_oe[48] |=> pin_pullup[48])
    else $error("pull-up lost outside bus groups");

  a_rdata_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R4
    setup && (in_data || in_dir) |=> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  a_read_level_port2: assert property (@(posedge pclk) disable iff (!presetn) // R4
    setup && in_data && (widx == 4'h2) |=> prdata[7:0] == $past(level[23:16]))
    else $error("port two read not pin level");

  a_reset_pads_low: assert property (@(posedge pclk) // R15
    !presetn |-> (pin_out == 88'h0) && (prdata == 32'h0))
    else $error("pad value or read data not cleared in reset");

  a_rbsel_write: assert property (@(posedge pclk) disable iff (!presetn) // R13
    access && pwrite && (paddr == piopb_pkg::OFS_PCTL) && pstrb[0]
    |=> s_r.rbsel == $past(pwdata[0]))
    else $error("readback select write lost");

  c_dir_write: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && in_dir);
  c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && in_data && exp_mode && (byte_of(bus_pin_mask, widx) != 8'h0));
  c_latch_readback: cover property (@(posedge pclk) disable iff (!presetn)
    setup && in_data && (widx == 4'h1) && rb_valid && s_r.rbsel);
  c_periph_drive: cover property (@(posedge pclk) disable iff (!presetn)
    periph_oe[10] && !s_r.dir[10]);
  c_mixed_readback: cover property (@(posedge pclk) disable iff (!presetn)
    setup && in_data && (widx == 4'h1) && rb_valid && !s_r.rbsel);
endmodule

// [tb/piopb_pads.sv]
// Purpose: Far-side model of the pads, resolving each pin to one level
// Assumes: Device drive wins over external drive on a contested pin
// Notes: A pin driven by nobody and not pulled up toggles every cycle
`timescale 1ns/10ps
module piopb_pads (
  // Clock
  input wire logic pclk,
  // Device side
  input wire logic [87:0] pin_out,
  input wire logic [87:0] pin_oe,
  input wire logic [87:0] pin_pullup,
  // External drivers
  input wire logic [87:0] ext_oe,
  input wire logic [87:0] ext_val,
  // Resolved level
  output logic [87:0] pin_lvl
);
  logic [87:0] float_r = 88'h0;
  always @(posedge pclk) float_r <= ~float_r;
  always_comb
  begin
    for (int i = 0; i < 88; i++)
    begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_oe[i]) pin_lvl[i] = ext_val[i];
      else if (pin_pullup[i]) pin_lvl[i] = 1'b1;
      // An unknown would settle arbitrarily, so float shows a moving pattern
      else pin_lvl[i] = float_r[i];
    end
  end
endmodule

// [tb/tb_programmable_io_port_bank.sv]
// Purpose: Self-checking bench for the port bank over APB
// Assumes: Zero-wait slave, pads registered one cycle after cause
// Notes: Pin reads wait out the synchroniser before sampling
`timescale 1ns/10ps
module tb_programmable_io_port_bank;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic w;
    logic [31:0] x;
    logic e;
  } piopb_row_s;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic exp_mode = 1'b0, bus_8bit = 1'b0, mux_port_mode = 1'b0;
  logic [1:0] da_enable = 2'h0;
  logic [87:0] bus_pin_mask = 88'h0, periph_oe = 88'h0, periph_out = 88'h0;
  logic [87:0] ext_oe = 88'h0, ext_val = 88'h0, pin_in, pin_out, pin_oe, pin_pullup;
  int err_total = 0, tests_run = 0;
  piopb_row_s rows [9];
  piopb_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exp_mode(exp_mode), .bus_8bit(bus_8bit),
    .mux_port_mode(mux_port_mode), .bus_pin_mask(bus_pin_mask), .periph_oe(periph_oe),
    .periph_out(periph_out), .da_enable(da_enable), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup));
  piopb_pads PADS (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_oe(ext_oe), .ext_val(ext_val), .pin_lvl(pin_in));
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  task automatic results();
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, d, 1'b1);
    repeat (6) @(posedge pclk);
  endtask
  initial
  begin
    #200000;
    err_total++;
    results();
  end
  initial
  begin
    rows[0] = '{12'h040, 32'h0, 1'b0, 32'h0, 1'b0};
    rows[1] = '{12'h080, 32'h0, 1'b0, 32'h0, 1'b0};
    rows[2] = '{12'h084, 32'h0, 1'b0, 32'h0, 1'b0};
    rows[3] = '{12'h04c, 32'ha5, 1'b1, 32'h0, 1'b0};
    rows[4] = '{12'h04c, 32'h0, 1'b0, 32'ha5, 1'b0};
    rows[5] = '{12'h0fc, 32'h77, 1'b1, 32'h0, 1'b1};
    rows[6] = '{12'h0fc, 32'h0, 1'b0, 32'h0, 1'b1};
    rows[7] = '{12'h060, 32'hff, 1'b1, 32'h0, 1'b0};
    rows[8] = '{12'h060, 32'h0, 1'b0, 32'hdf, 1'b0};
    // A real falling edge, so the asynchronous reset acts before the first clock
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({24'h0, pin_oe[7:0]}, 32'h0);
    chk({24'h0, pin_pullup[7:0]}, 32'h0);
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].d, rows[i].w);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    wr(12'h040, 32'hff);
    wr(12'h000, 32'h3c);
    chk({24'h0, pin_oe[7:0]}, 32'hff);
    chk({24'h0, pin_out[7:0]}, 32'h3c);
    apb(12'h000, 32'h0, 1'b0);
    chk(rd, 32'h3c);
    ext_oe[23:16] <= 8'hff;
    ext_val[23:16] <= 8'h5a;
    wr(12'h048, 32'h01);
    apb(12'h008, 32'h0, 1'b0);
    chk(rd, 32'h5a);
    wr(12'h080, 32'h3fffff);
    chk({28'h0, pin_pullup[19:16]}, 32'he);
    chk({30'h0, pin_oe[69], pin_pullup[69]}, 32'h0);
    periph_oe[10] <= 1'b1;
    periph_out[10] <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({30'h0, pin_oe[10], pin_out[10]}, 32'h3);
    periph_oe[10] <= 1'b0;
    // Analog output pins stay inputs
    wr(12'h064, 32'h00);
    da_enable <= 2'h3;
    repeat (3) @(posedge pclk);
    chk({29'h0, pin_pullup[76:74]}, 32'h1);
    exp_mode <= 1'b1;
    bus_pin_mask[7:0] <= 8'hff;
    wr(12'h040, 32'h00);
    wr(12'h000, 32'h00);
    chk({24'h0, pin_oe[7:0]}, 32'hff);
    chk({24'h0, pin_out[7:0]}, 32'h3c);
    apb(12'h040, 32'h0, 1'b0);
    chk(rd, 32'hff);
    chk({24'h0, pin_pullup[51:48], pin_pullup[27:24]}, 32'hf0);
    wr(12'h080, 32'h3ffffe);
    apb(12'h080, 32'h0, 1'b0);
    chk(rd, 32'h3ffffe);
    bus_8bit <= 1'b1;
    ext_oe[15:8] <= 8'hff;
    ext_val[15:8] <= 8'h55;
    wr(12'h044, 32'h0f);
    apb(12'h088, 32'h0, 1'b0);
    chk(rd, 32'h1b);
    wr(12'h004, 32'haa);
    wr(12'h084, 32'h1);
    apb(12'h004, 32'h0, 1'b0);
    chk(rd, 32'haa);
    wr(12'h084, 32'h0);
    apb(12'h004, 32'h0, 1'b0);
    chk(rd, 32'h5a);
    wr(12'h084, 32'h1);
    bus_8bit <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(12'h004, 32'h0, 1'b0);
    chk(rd, 32'h5a);
    exp_mode <= 1'b0;
    mux_port_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(12'h004, 32'h0, 1'b0);
    chk(rd, 32'haa);
    // Reset in mid-run must clear settings made earlier
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h0, |pin_oe, |pin_pullup}, 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h044, 32'h0, 1'b0);
    chk(rd, 32'h0);
    apb(12'h080, 32'h0, 1'b0);
    chk(rd, 32'h0);
    results();
  end
endmodule
